// ---- hdl/drmx_pkg.sv ----
// What this block does
// - Writing command code 29h starts the 48-bit multi-sector read, which fetches the sectors and returns them.
// - Every sector's data leaves through the data register as 16-bit words, one word per host data read.
// - One interrupt is raised per block of the configured block size, not per sector.
// - A combined sector count of zero transfers 65,536 sectors.
// - After an unrecoverable error the address of the failing sector is readable, low or high half by the select bit.
// - Writing command code F8h returns the native maximum address in the address registers with no data transfer.
// - The native maximum returned is the physical limit, unaffected by any reduced capacity.
// - A native maximum above 268,435,455 is returned as 268,435,455.
// - In address mode the native maximum bits 0-7 go to the sector number register.
// - In address mode bits 8-15 go to cylinder low and bits 16-23 to cylinder high.
// - In address mode bits 24-27 go to the head bits of the drive select register.
// - In cylinder-head-sector mode the maximum sector, cylinder and head are returned instead.
package drmx_pkg;
   localparam logic [7:0] CMD_RD_MULTI_EXT = 8'h29;
   localparam logic [7:0] CMD_NATIVE_MAX = 8'hF8;
   localparam logic [2:0] ADR_DATA = 3'h0;
   localparam logic [2:0] ADR_ERR_FEAT = 3'h1;
   localparam logic [2:0] ADR_SCNT = 3'h2;
   localparam logic [2:0] ADR_SNUM = 3'h3;
   localparam logic [2:0] ADR_CYLLO = 3'h4;
   localparam logic [2:0] ADR_CYLHI = 3'h5;
   localparam logic [2:0] ADR_DEVHEAD = 3'h6;
   localparam logic [2:0] ADR_STAT_CMD = 3'h7;
   localparam logic [2:0] ADR_DEVCTL = 3'h6;
   localparam logic [8:0] WORD_LAST = 9'h0FF;
   localparam logic [16:0] MAX_SECTORS = 17'h1_0000;
   localparam logic [47:0] NATIVE_CLAMP = 48'h0000_0FFF_FFFF;
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ER_UNC = 6;
   localparam int ER_ABT = 2;
   localparam int DH_LBA = 6;
   localparam int DC_HOB = 7;
   localparam logic [7:0] ERR_RESET = 8'h00;
   localparam logic [7:0] DEVHEAD_RESET = 8'hA0;

   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] cur;
   } drmx_pair_t;

   typedef struct packed {
      drmx_pair_t scnt;
      drmx_pair_t snum;
      drmx_pair_t cyllo;
      drmx_pair_t cylhi;
      logic [7:0] feat;
      logic [7:0] devhead;
   } drmx_tf_t;

   typedef struct packed {
      logic [7:0] sect;
      logic [15:0] cyl;
      logic [3:0] head;
   } drmx_addr_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_STREAM = 3'b010,
      ST_NMAX = 3'b011,
      ST_NMAX2 = 3'b100
   } drmx_state_t;
endpackage

// ---- hdl/drmx_fifo.sv ----
`timescale 1ns/10ps
`default_nettype none
module drmx_fifo
   import drmx_pkg::*;
#(
   parameter int W = 16,
   parameter int DEPTH = 4
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic in_rdy;
      logic out_vld;
   } drmx_fifo_state_t;

   drmx_fifo_state_t s_r, s_nxt;
   logic push, pop;

   always_comb begin
      s_nxt = s_r;
      push = in_valid_i && s_r.in_rdy;
      pop = out_ready_i && s_r.out_vld;
      if (flush_i) begin
         s_nxt.wp = '0;
         s_nxt.rp = '0;
         s_nxt.cnt = '0;
      end else begin
         if (push) begin
            s_nxt.mem[s_r.wp] = in_data_i;
            s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
         end
         if (pop) begin
            s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
         end
         s_nxt.cnt = s_r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      end
      // Flags are registered so the media side sees a clean ready with no path from the host side.
      s_nxt.in_rdy = s_nxt.cnt != (AW + 1)'(DEPTH);
      s_nxt.out_vld = s_nxt.cnt != '0;
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign in_ready_o = s_r.in_rdy;
   assign out_valid_o = s_r.out_vld;
   assign out_data_o = s_r.mem[s_r.rp];

   property p_full_stalls;
      @(posedge core_clk_i) disable iff (reset_i)
      (s_r.cnt == (AW + 1)'(DEPTH)) |-> !in_ready_o;
   endproperty
   a_full_stalls: assert property (p_full_stalls)
      else $error("fifo full but still ready");
endmodule
`default_nettype wire

// ---- hdl/drmx_nmax.sv ----
`timescale 1ns/10ps
`default_nettype none
module drmx_nmax
   import drmx_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic lba_mode_i,
   input wire logic [47:0] native_max_i,
   input wire logic [15:0] chs_max_cyl_i,
   input wire logic [3:0] chs_max_head_i,
   input wire logic [7:0] chs_max_sect_i,
   output drmx_addr_t answer_o
);
   typedef struct packed {
      drmx_addr_t ans;
   } drmx_nmax_state_t;

   drmx_nmax_state_t s_r, s_nxt;
   logic [27:0] lim;

   always_comb begin
      s_nxt = s_r;
      // Only the physical limit is an input; no reduced capacity is ever consulted.
      lim = (native_max_i > NATIVE_CLAMP) ? NATIVE_CLAMP[27:0] : native_max_i[27:0];
      if (lba_mode_i) begin
         s_nxt.ans.sect = lim[7:0];
         s_nxt.ans.cyl = lim[23:8];
         s_nxt.ans.head = lim[27:24];
      end else begin
         s_nxt.ans.sect = chs_max_sect_i;
         s_nxt.ans.cyl = chs_max_cyl_i;
         s_nxt.ans.head = chs_max_head_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign answer_o = s_r.ans;

   property p_clamp;
      @(posedge core_clk_i) disable iff (reset_i)
      (lba_mode_i && native_max_i > NATIVE_CLAMP) |=> ({answer_o.head, answer_o.cyl, answer_o.sect} == 28'hFFF_FFFF);
   endproperty
   a_clamp: assert property (p_clamp)
      else $error("native maximum not saturated");

   property p_lba_map;
      @(posedge core_clk_i) disable iff (reset_i)
      (lba_mode_i && native_max_i <= NATIVE_CLAMP)
         |=> ({answer_o.head, answer_o.cyl, answer_o.sect} == $past(native_max_i[27:0]));
   endproperty
   a_lba_map: assert property (p_lba_map)
      else $error("native maximum address fields misplaced");
endmodule
`default_nettype wire

// ---- hdl/drmx_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module drmx_top
   import drmx_pkg::*;
#(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic host_ctl_sel_i,
   input wire logic [2:0] host_addr_i,
   input wire logic host_wr_i,
   input wire logic host_rd_i,
   input wire logic [15:0] host_wdata_i,
   output logic [15:0] host_rdata_o,
   output logic intrq_o,
   output logic med_req_o,
   output logic [47:0] med_lba_o,
   input wire logic med_valid_i,
   input wire logic [15:0] med_data_i,
   input wire logic med_err_i,
   output logic med_ready_o,
   input wire logic [7:0] multi_count_i,
   input wire logic [47:0] native_max_i,
   input wire logic [15:0] chs_max_cyl_i,
   input wire logic [3:0] chs_max_head_i,
   input wire logic [7:0] chs_max_sect_i
);
   typedef struct packed {
      drmx_state_t st;
      drmx_tf_t tf;
      logic high_byte_select;
      logic [7:0] error_flags;
      logic err_bit;
      logic intr;
      logic [15:0] rdata;
      logic med_req;
      logic [47:0] lba;
      logic [16:0] left;
      logic [8:0] wcnt;
      logic [7:0] blk_left;
      logic flush;
   } drmx_top_state_t;

   drmx_top_state_t s_r, s_nxt;
   logic fifo_vld;
   logic [15:0] fifo_data;
   logic pop;
   logic tf_wr;
   logic tf_rd;
   logic cmd_wr;
   logic stat_rd;
   logic [15:0] cnt16;
   logic [7:0] status_flags;
   logic transfer_request_flag;
   logic device_occupied_flag;
   drmx_addr_t nmax_ans;

   drmx_fifo #(
      .W(16),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .flush_i(s_r.flush),
      .in_valid_i(med_valid_i),
      .in_data_i(med_data_i),
      .in_ready_o(med_ready_o),
      .out_valid_o(fifo_vld),
      .out_data_o(fifo_data),
      .out_ready_i(pop)
   );

   drmx_nmax u_nmax (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .lba_mode_i(s_r.tf.devhead[DH_LBA]),
      .native_max_i(native_max_i),
      .chs_max_cyl_i(chs_max_cyl_i),
      .chs_max_head_i(chs_max_head_i),
      .chs_max_sect_i(chs_max_sect_i),
      .answer_o(nmax_ans)
   );

   always_comb begin
      tf_wr = host_wr_i && !host_ctl_sel_i && s_r.st == ST_IDLE;
      tf_rd = host_rd_i && !host_ctl_sel_i;
      cmd_wr = tf_wr && host_addr_i == ADR_STAT_CMD;
      stat_rd = tf_rd && host_addr_i == ADR_STAT_CMD;
      pop = tf_rd && host_addr_i == ADR_DATA && s_r.st == ST_STREAM && fifo_vld;
      cnt16 = {s_r.tf.scnt.prev, s_r.tf.scnt.cur};
      // Busy stays up while the buffer runs dry so the host never reads a stale word.
      transfer_request_flag = s_r.st == ST_STREAM && fifo_vld;
      device_occupied_flag = s_r.st != ST_IDLE && !transfer_request_flag;
      status_flags = 8'h00;
      status_flags[ST_BSY] = device_occupied_flag;
      status_flags[ST_RDY] = 1'b1;
      status_flags[ST_DSC] = 1'b1;
      status_flags[ST_DRQ] = transfer_request_flag;
      status_flags[ST_ERR] = s_r.err_bit;
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.med_req = 1'b0;
      s_nxt.flush = 1'b0;

      // Read path: the register answers one cycle after the strobe.
      if (host_rd_i) begin
         if (host_ctl_sel_i) begin
            s_nxt.rdata = (host_addr_i == ADR_DEVCTL) ? {8'h00, status_flags} : 16'h0000;
         end else begin
            unique case (host_addr_i)
               ADR_DATA: s_nxt.rdata = pop ? fifo_data : 16'h0000;
               ADR_ERR_FEAT: s_nxt.rdata = {8'h00, s_r.error_flags};
               ADR_SCNT: s_nxt.rdata = {8'h00, s_r.high_byte_select ? s_r.tf.scnt.prev : s_r.tf.scnt.cur};
               ADR_SNUM: s_nxt.rdata = {8'h00, s_r.high_byte_select ? s_r.tf.snum.prev : s_r.tf.snum.cur};
               ADR_CYLLO: s_nxt.rdata = {8'h00, s_r.high_byte_select ? s_r.tf.cyllo.prev : s_r.tf.cyllo.cur};
               ADR_CYLHI: s_nxt.rdata = {8'h00, s_r.high_byte_select ? s_r.tf.cylhi.prev : s_r.tf.cylhi.cur};
               ADR_DEVHEAD: s_nxt.rdata = {8'h00, s_r.tf.devhead};
               ADR_STAT_CMD: s_nxt.rdata = {8'h00, status_flags};
            endcase
         end
      end

      // Reading the main status acknowledges the interrupt.
      if (stat_rd) begin
         s_nxt.intr = 1'b0;
      end

      if (host_wr_i && host_ctl_sel_i && host_addr_i == ADR_DEVCTL) begin
         s_nxt.high_byte_select = host_wdata_i[DC_HOB];
      end

      if (tf_wr) begin
         // The count, sector and cylinder registers keep the byte written before it, giving the high half of 48-bit fields.
         unique case (host_addr_i)
            ADR_DATA: ;
            ADR_ERR_FEAT: s_nxt.tf.feat = host_wdata_i[7:0];
            ADR_SCNT: s_nxt.tf.scnt = {s_r.tf.scnt.cur, host_wdata_i[7:0]};
            ADR_SNUM: s_nxt.tf.snum = {s_r.tf.snum.cur, host_wdata_i[7:0]};
            ADR_CYLLO: s_nxt.tf.cyllo = {s_r.tf.cyllo.cur, host_wdata_i[7:0]};
            ADR_CYLHI: s_nxt.tf.cylhi = {s_r.tf.cylhi.cur, host_wdata_i[7:0]};
            ADR_DEVHEAD: s_nxt.tf.devhead = host_wdata_i[7:0];
            ADR_STAT_CMD: ;
         endcase
         s_nxt.high_byte_select = 1'b0;
      end

      if (cmd_wr) begin
         s_nxt.intr = 1'b0;
         s_nxt.error_flags = ERR_RESET;
         s_nxt.err_bit = 1'b0;
         s_nxt.flush = 1'b1;
         if (host_wdata_i[7:0] == CMD_RD_MULTI_EXT && multi_count_i != 8'h00) begin
            s_nxt.st = ST_FETCH;
            s_nxt.lba = {s_r.tf.cylhi.prev, s_r.tf.cyllo.prev, s_r.tf.snum.prev,
                         s_r.tf.cylhi.cur, s_r.tf.cyllo.cur, s_r.tf.snum.cur};
            s_nxt.left = (cnt16 == 16'h0000) ? MAX_SECTORS : {1'b0, cnt16};
            s_nxt.blk_left = 8'h00;
         end else if (host_wdata_i[7:0] == CMD_NATIVE_MAX) begin
            s_nxt.st = ST_NMAX;
         end else begin
            // Unknown commands and a multi read with no block size set are refused.
            s_nxt.error_flags[ER_ABT] = 1'b1;
            s_nxt.err_bit = 1'b1;
            s_nxt.intr = 1'b1;
         end
      end

      unique case (s_r.st)
         ST_IDLE: ;
         ST_FETCH: begin
            s_nxt.med_req = 1'b1;
            s_nxt.wcnt = 9'h000;
            s_nxt.st = ST_STREAM;
            if (s_r.blk_left == 8'h00) begin
               s_nxt.intr = 1'b1;
               s_nxt.blk_left = multi_count_i - 8'h01;
            end else begin
               s_nxt.blk_left = s_r.blk_left - 8'h01;
            end
         end
         ST_STREAM: begin
            if (med_err_i) begin
               s_nxt.tf.snum = {s_r.lba[31:24], s_r.lba[7:0]};
               s_nxt.tf.cyllo = {s_r.lba[39:32], s_r.lba[15:8]};
               s_nxt.tf.cylhi = {s_r.lba[47:40], s_r.lba[23:16]};
               s_nxt.error_flags[ER_UNC] = 1'b1;
               s_nxt.err_bit = 1'b1;
               s_nxt.intr = 1'b1;
               s_nxt.flush = 1'b1;
               s_nxt.st = ST_IDLE;
            end else if (pop) begin
               s_nxt.wcnt = s_r.wcnt + 9'h001;
               if (s_r.wcnt == WORD_LAST) begin
                  s_nxt.lba = s_r.lba + 48'h0000_0000_0001;
                  s_nxt.left = s_r.left - 17'h0_0001;
                  s_nxt.st = (s_r.left == 17'h0_0001) ? ST_IDLE : ST_FETCH;
               end
            end
         end
         ST_NMAX: s_nxt.st = ST_NMAX2;
         ST_NMAX2: begin
            s_nxt.tf.snum.cur = nmax_ans.sect;
            s_nxt.tf.cyllo.cur = nmax_ans.cyl[7:0];
            s_nxt.tf.cylhi.cur = nmax_ans.cyl[15:8];
            s_nxt.tf.devhead[3:0] = nmax_ans.head;
            s_nxt.intr = 1'b1;
            s_nxt.st = ST_IDLE;
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s_r <= '0;
         s_r.st <= ST_IDLE;
         s_r.tf.devhead <= DEVHEAD_RESET;
         s_r.error_flags <= ERR_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign host_rdata_o = s_r.rdata;
   assign intrq_o = s_r.intr;
   assign med_req_o = s_r.med_req;
   assign med_lba_o = s_r.lba;

   property p_cmd_start;
      @(posedge core_clk_i) disable iff (reset_i)
      (cmd_wr && host_wdata_i[7:0] == CMD_RD_MULTI_EXT && multi_count_i != 8'h00)
         |=> (s_r.st == ST_FETCH) ##1 (med_req_o && s_r.st == ST_STREAM);
   endproperty
   a_cmd_start: assert property (p_cmd_start)
      else $error("multi read did not request the first sector");

   property p_word_out;
      @(posedge core_clk_i) disable iff (reset_i)
      pop |=> (host_rdata_o == $past(fifo_data));
   endproperty
   a_word_out: assert property (p_word_out)
      else $error("data word not returned on host read");

   property p_block_intr;
      @(posedge core_clk_i) disable iff (reset_i)
      (s_r.st == ST_FETCH && s_r.blk_left != 8'h00 && !stat_rd && !intrq_o) |=> !intrq_o;
   endproperty
   a_block_intr: assert property (p_block_intr)
      else $error("interrupt raised inside a block");

   property p_block_start;
      @(posedge core_clk_i) disable iff (reset_i)
      (s_r.st == ST_FETCH && s_r.blk_left == 8'h00) |=> intrq_o;
   endproperty
   a_block_start: assert property (p_block_start)
      else $error("no interrupt at block start");

   property p_zero_count;
      @(posedge core_clk_i) disable iff (reset_i)
      (cmd_wr && host_wdata_i[7:0] == CMD_RD_MULTI_EXT && multi_count_i != 8'h00 && cnt16 == 16'h0000)
         |=> (s_r.left == MAX_SECTORS);
   endproperty
   a_zero_count: assert property (p_zero_count)
      else $error("zero count not taken as maximum");

   property p_err_addr;
      @(posedge core_clk_i) disable iff (reset_i)
      (s_r.st == ST_STREAM && med_err_i)
         |=> ({s_r.tf.cylhi.prev, s_r.tf.cyllo.prev, s_r.tf.snum.prev,
               s_r.tf.cylhi.cur, s_r.tf.cyllo.cur, s_r.tf.snum.cur} == $past(s_r.lba)) && intrq_o;
   endproperty
   a_err_addr: assert property (p_err_addr)
      else $error("failing address not reported");

   property p_nmax_done;
      @(posedge core_clk_i) disable iff (reset_i)
      (cmd_wr && host_wdata_i[7:0] == CMD_NATIVE_MAX)
         |=> (s_r.st == ST_NMAX) ##1 (s_r.st == ST_NMAX2) ##1 (s_r.st == ST_IDLE && intrq_o && !pop);
   endproperty
   a_nmax_done: assert property (p_nmax_done)
      else $error("native maximum query did not complete");
endmodule
`default_nettype wire

// ---- sim/drmx_media_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module drmx_media_model
   import drmx_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic req_i,
   input wire logic [47:0] lba_i,
   input wire logic ready_i,
   input wire logic slow_i,
   input wire logic err_en_i,
   input wire logic [47:0] err_lba_i,
   output logic valid_o,
   output logic [15:0] data_o,
   output logic err_o
);
   // Each request yields one sector of 256 words, each word tagged with its address and index.
   logic [47:0] lba;
   logic took;
   logic pend;
   logic gap;
   int left;
   int idx;
   initial begin
      valid_o = 1'b0;
      data_o = 16'h0000;
      err_o = 1'b0;
      took = 1'b0;
      pend = 1'b0;
      gap = 1'b0;
      left = 0;
      idx = 0;
   end
   always @(posedge core_clk_i) begin
      took <= valid_o && ready_i;
      pend <= req_i;
      if (req_i) begin
         lba <= lba_i;
      end
   end
   always @(negedge core_clk_i) begin
      err_o <= 1'b0;
      if (took) begin
         idx = idx + 1;
         left = left - 1;
      end
      if (pend) begin
         left = 256;
         idx = 0;
      end
      if (reset_i) begin
         left = 0;
      end
      // The fault strikes while the buffer still has room, so it fires even when the host reads nothing.
      if (left > 0 && err_en_i && lba == err_lba_i && idx == 2) begin
         err_o <= 1'b1;
         left = 0;
      end
      // A word on offer is held until it is taken; an idle bus toggles so no stale word looks valid.
      if (left == 0 || (slow_i && !gap && !(valid_o && !took))) begin
         gap = (left != 0);
         valid_o <= 1'b0;
         data_o <= ~data_o;
      end else if (!(valid_o && !took)) begin
         gap = 1'b0;
         valid_o <= 1'b1;
         data_o <= {lba[7:0], idx[7:0]};
      end
   end
endmodule
`default_nettype wire

// ---- sim/test_disk_read_multi_ext_native_max.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_disk_read_multi_ext_native_max
   import drmx_pkg::*;
;
   typedef struct packed {
      logic mode;
      logic [47:0] nat;
      logic [15:0] cyl;
      logic [3:0] hd;
      logic [7:0] sc;
      logic [23:0] e_adr;
      logic [3:0] e_hd;
   } drmx_row_t;
   logic core_clk_i, host_ctl_sel_i, host_wr_i, host_rd_i, intrq_o, med_req_o, med_valid_i, med_err_i;
   logic reset_i = 1'b1;
   logic med_ready_o, slow, err_en;
   logic [2:0] host_addr_i;
   logic [15:0] host_wdata_i, host_rdata_o, med_data_i, chs_max_cyl_i;
   logic [47:0] med_lba_o, native_max_i, exp_lba, err_lba;
   logic [7:0] multi_count_i, chs_max_sect_i;
   logic [3:0] chs_max_head_i;
   drmx_row_t rows [4];
   int checked = 0;
   int n_fail = 0;
   int n_irq = 0;
   drmx_top #(.FIFO_DEPTH(4)) dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .host_ctl_sel_i(host_ctl_sel_i),
      .host_addr_i(host_addr_i), .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i),
      .host_rdata_o(host_rdata_o), .intrq_o(intrq_o), .med_req_o(med_req_o), .med_lba_o(med_lba_o),
      .med_valid_i(med_valid_i), .med_data_i(med_data_i), .med_err_i(med_err_i), .med_ready_o(med_ready_o),
      .multi_count_i(multi_count_i), .native_max_i(native_max_i), .chs_max_cyl_i(chs_max_cyl_i),
      .chs_max_head_i(chs_max_head_i), .chs_max_sect_i(chs_max_sect_i));
   drmx_media_model mdl (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(med_req_o), .lba_i(med_lba_o),
      .ready_i(med_ready_o), .slow_i(slow), .err_en_i(err_en), .err_lba_i(err_lba), .valid_o(med_valid_i),
      .data_o(med_data_i), .err_o(med_err_i));
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   task automatic summarize();
      $display("checked %0d, n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic timeout();
      n_fail++;
      $display("unexpected wait: expected completion, seen timeout");
      summarize();
   endtask
   task automatic wr(input logic c, input logic [2:0] a, input logic [15:0] v);
      @(negedge core_clk_i);
      host_ctl_sel_i = c;
      host_addr_i = a;
      host_wdata_i = v;
      host_wr_i = 1'b1;
      @(negedge core_clk_i);
      host_wr_i = 1'b0;
   endtask
   task automatic rd(input logic c, input logic [2:0] a, output logic [15:0] v);
      @(negedge core_clk_i);
      host_ctl_sel_i = c;
      host_addr_i = a;
      host_rd_i = 1'b1;
      @(negedge core_clk_i);
      host_rd_i = 1'b0;
      v = host_rdata_o;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [15:0] e, input string n);
      logic [15:0] v;
      rd(1'b0, a, v);
      chk(n, e, v);
   endtask
   // Alternate status is polled so that a pending interrupt is not lost to the poll itself.
   task automatic wait_bit(input int b, input logic v);
      logic [15:0] d;
      for (int i = 0; i < 100; i++) begin
         rd(1'b1, ADR_DEVCTL, d);
         if (d[b] === v) return;
      end
      timeout();
   endtask
   task automatic wait_drq();
      logic [15:0] d;
      for (int i = 0; i < 400; i++) begin
         if (intrq_o === 1'b1) begin
            rd(1'b0, ADR_STAT_CMD, d);
            n_irq++;
         end
         rd(1'b1, ADR_DEVCTL, d);
         if (d[ST_DRQ] === 1'b1) return;
      end
      timeout();
   endtask
   task automatic start_read(input logic [15:0] cnt, input logic [47:0] lba);
      wr(1'b0, ADR_SCNT, {8'h00, cnt[15:8]});
      wr(1'b0, ADR_SCNT, {8'h00, cnt[7:0]});
      wr(1'b0, ADR_SNUM, {8'h00, lba[31:24]});
      wr(1'b0, ADR_SNUM, {8'h00, lba[7:0]});
      wr(1'b0, ADR_CYLLO, {8'h00, lba[39:32]});
      wr(1'b0, ADR_CYLLO, {8'h00, lba[15:8]});
      wr(1'b0, ADR_CYLHI, {8'h00, lba[47:40]});
      wr(1'b0, ADR_CYLHI, {8'h00, lba[23:16]});
      wr(1'b0, ADR_DEVHEAD, 16'h00E0);
      exp_lba = lba;
      n_irq = 0;
      wr(1'b0, ADR_STAT_CMD, {8'h00, CMD_RD_MULTI_EXT});
   endtask
   task automatic read_sector(input logic [47:0] lba);
      logic [15:0] d;
      for (int i = 0; i < 256; i++) begin
         wait_drq();
         rd(1'b0, ADR_DATA, d);
         chk("data word", {lba[7:0], i[7:0]}, d);
      end
   endtask
   always @(posedge core_clk_i) begin
      if (!reset_i && med_req_o === 1'b1) begin
         chk("med_lba", exp_lba, med_lba_o);
         exp_lba <= exp_lba + 48'h0000_0000_0001;
      end
   end
   initial begin
      logic [15:0] d;
      host_ctl_sel_i = 1'b0;
      host_addr_i = 3'h0;
      host_wr_i = 1'b0;
      host_rd_i = 1'b0;
      host_wdata_i = 16'h0000;
      slow = 1'b0;
      err_en = 1'b0;
      err_lba = 48'h0000_0000_0000;
      exp_lba = 48'h0000_0000_0000;
      multi_count_i = 8'h01;
      rows[0] = '{1'b1, 48'h0000_0123_4567, 16'h1111, 4'h2, 8'h33, 24'h23_4567, 4'h1};
      rows[1] = '{1'b1, 48'h0000_1234_5678, 16'h1111, 4'h2, 8'h33, 24'hFF_FFFF, 4'hF};
      rows[2] = '{1'b1, 48'h0000_0FFF_FFFF, 16'h1111, 4'h2, 8'h33, 24'hFF_FFFF, 4'hF};
      rows[3] = '{1'b0, 48'hFFFF_FFFF_FFFF, 16'h3FFF, 4'hE, 8'h3F, 24'h3F_FF3F, 4'hE};
      native_max_i = rows[0].nat;
      chs_max_cyl_i = rows[0].cyl;
      chs_max_head_i = rows[0].hd;
      chs_max_sect_i = rows[0].sc;
      repeat (12) @(negedge core_clk_i);
      reset_i = 1'b0;
      for (int r = 0; r < 4; r++) begin
         native_max_i = rows[r].nat;
         chs_max_cyl_i = rows[r].cyl;
         chs_max_head_i = rows[r].hd;
         chs_max_sect_i = rows[r].sc;
         wr(1'b0, ADR_DEVHEAD, rows[r].mode ? 16'h00E0 : 16'h00A0);
         wr(1'b0, ADR_STAT_CMD, {8'h00, CMD_NATIVE_MAX});
         wait_bit(ST_BSY, 1'b0);
         chk("nmax intrq", 1'b1, intrq_o);
         rdc(ADR_SNUM, rows[r].e_adr[7:0], "nmax sector");
         rdc(ADR_CYLLO, rows[r].e_adr[15:8], "nmax cyl low");
         rdc(ADR_CYLHI, rows[r].e_adr[23:16], "nmax cyl high");
         rdc(ADR_DEVHEAD, (rows[r].mode ? 8'hE0 : 8'hA0) | rows[r].e_hd, "nmax head");
         rdc(ADR_STAT_CMD, 16'h0050, "nmax status");
      end
      // A second reset in mid-run must bring back the idle register values.
      reset_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      reset_i = 1'b0;
      @(negedge core_clk_i);
      chk("rdata", 16'h0000, host_rdata_o);
      chk("intrq", 1'b0, intrq_o);
      chk("med_ready", 1'b1, med_ready_o);
      rdc(ADR_DEVHEAD, 16'h00A0, "drive_select_head");
      rdc(ADR_ERR_FEAT, 16'h0000, "error_flags");
      rdc(ADR_STAT_CMD, 16'h0050, "status_flags");
      rdc(ADR_DATA, 16'h0000, "idle data");
      multi_count_i = 8'h00;
      foreach (rows[k]) begin
         if (k < 2) begin
            wr(1'b0, ADR_STAT_CMD, k == 0 ? {8'h00, CMD_RD_MULTI_EXT} : 16'h00C4);
            @(negedge core_clk_i);
            chk("abort intrq", 1'b1, intrq_o);
            rdc(ADR_ERR_FEAT, 16'h0004, "abort error");
            rdc(ADR_STAT_CMD, 16'h0051, "abort status");
         end
      end
      multi_count_i = 8'h02;
      slow = 1'b1;
      start_read(16'h0003, 48'hA1B2_C3D4_E5F6);
      repeat (30) @(negedge core_clk_i);
      chk("fifo full", 1'b0, med_ready_o);
      for (int s = 0; s < 3; s++) begin
         read_sector(48'hA1B2_C3D4_E5F6 + s);
      end
      wait_bit(ST_BSY, 1'b0);
      chk("block interrupts", 2, n_irq);
      chk("sectors fetched", 48'hA1B2_C3D4_E5F9, exp_lba);
      rdc(ADR_STAT_CMD, 16'h0050, "end status");
      rdc(ADR_DATA, 16'h0000, "drained data");
      multi_count_i = 8'h01;
      slow = 1'b0;
      err_en = 1'b1;
      err_lba = 48'h1234_5678_9B00;
      start_read(16'h0000, 48'h1234_5678_9AFF);
      read_sector(48'h1234_5678_9AFF);
      wait_bit(ST_ERR, 1'b1);
      chk("error intrq", 1'b1, intrq_o);
      chk("sectors fetched", 48'h1234_5678_9B01, exp_lba);
      rdc(ADR_ERR_FEAT, 16'h0040, "error flags");
      rdc(ADR_STAT_CMD, 16'h0051, "error status");
      rdc(ADR_SNUM, 16'h0000, "fail lba 7:0");
      rdc(ADR_CYLLO, 16'h009B, "fail lba 15:8");
      rdc(ADR_CYLHI, 16'h0078, "fail lba 23:16");
      wr(1'b1, ADR_DEVCTL, 16'h0080);
      rdc(ADR_SNUM, 16'h0056, "fail lba 31:24");
      rdc(ADR_CYLLO, 16'h0034, "fail lba 39:32");
      rdc(ADR_CYLHI, 16'h0012, "fail lba 47:40");
      summarize();
   end
endmodule
`default_nettype wire
